// *** rtl/ebra_regs.vh ***
`ifndef EBRA_REGS_VH
`define EBRA_REGS_VH
// ****************************************************************
// timing counts and field positions
// ****************************************************************
`define EBRA_CLK_PERIOD_NS 4
`define EBRA_CFG_WAIT_W 4
`define EBRA_RDY_SYNC_STAGES 2
// gaps in ref_clk cycles: one bus clock output cycle is two of them
`define EBRA_DEMUX_GAP 3'h0
`define EBRA_MUX_GAP 3'h2
`define EBRA_MUX_TRI_GAP 3'h4
`endif

// *** rtl/ebra_sync.v ***
// ****************************************************************
// two-stage synchroniser for an input from outside the clock domain
// ****************************************************************
module ebra_sync #(
   parameter RESET_VAL = 1'b1
) (
   input wire ref_clk,
   input wire rstn,
   input wire clk_en,
   input wire async_in,
   output reg sync_out
);
   reg meta;

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else if (clk_en) begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule // ebra_sync

// *** rtl/ebra_ctrl.v ***
// Chosen here: the address-and-strobe port and the address map.
`include "ebra_regs.vh"

module ebra_ctrl #(
   parameter CS_W = 5,
   parameter WAIT_W = `EBRA_CFG_WAIT_W
) (
   input wire ref_clk,
   input wire rstn,
   input wire clk_en,
   input wire cyc_req,
   input wire cyc_write,
   input wire [CS_W-1:0] cyc_cs,
   input wire [WAIT_W-1:0] memory_cycle_wait_count,
   input wire rw_delay,
   input wire address_phase_wait_state,
   input wire tristate_wait_state,
   input wire own_need_bus,
   input wire ready_n,
   input wire hold_n,
   output reg cyc_ack,
   output reg cyc_done,
   output reg bus_clock_output,
   output reg rd_n,
   output reg wr_n,
   output reg [CS_W-1:0] cs_n_out,
   output reg cs_n_oe,
   output reg ctl_oe,
   output reg grant_acknowledge_out,
   output reg bus_regain_request,
   output reg bus_granted
);
   // ****************************************************************
   // state codes
   // ****************************************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_DELAY = 3'h1;
   localparam ST_WAIT = 3'h2;
   localparam ST_SAMPLE = 3'h3;
   localparam ST_GAP = 3'h4;
   localparam ST_HELD = 3'h5;
   localparam ST_REGAIN = 3'h6;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [WAIT_W-1:0] wait_cnt;
   reg [WAIT_W-1:0] next_wait_cnt;
   reg [2:0] gap_cnt;
   reg [2:0] next_gap_cnt;
   reg [1:0] rdy_age;
   wire rdy_ok;
   reg cmd_write;
   reg [CS_W-1:0] cmd_cs;
   reg clk_phase;
   wire ready_s;
   wire hold_s;
   wire hold_edge;

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   ebra_sync #(.RESET_VAL(1'b1)) u_ready_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .async_in(ready_n),
      .sync_out(ready_s)
   );

   ebra_sync #(.RESET_VAL(1'b1)) u_hold_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .async_in(hold_n),
      .sync_out(hold_s)
   );

   // hold is only looked at when the bus clock output is about to rise
   assign hold_edge = (clk_phase == 1'b0);

   // ready of the previous cycle is still in the synchroniser for a while
   assign rdy_ok = (rdy_age >= 2'h2);

   // ****************************************************************
   // next state
   // ****************************************************************
   always @* begin
      next_state = state;
      next_wait_cnt = wait_cnt;
      next_gap_cnt = gap_cnt;
      case (state)
         ST_IDLE: begin
            if (hold_edge && !hold_s) begin
               next_state = ST_HELD;
            end else if (cyc_req) begin
               next_wait_cnt = memory_cycle_wait_count;
               if (rw_delay) begin
                  next_state = ST_DELAY;
               end else if (memory_cycle_wait_count != {WAIT_W{1'b0}}) begin
                  next_state = ST_WAIT;
               end else begin
                  next_state = ST_SAMPLE;
               end
            end
         end
         ST_DELAY: begin
            if (wait_cnt != {WAIT_W{1'b0}}) begin
               next_state = ST_WAIT;
            end else begin
               next_state = ST_SAMPLE;
            end
         end
         ST_WAIT: begin
            next_wait_cnt = wait_cnt - {{(WAIT_W-1){1'b0}}, 1'b1};
            if (wait_cnt == {{(WAIT_W-1){1'b0}}, 1'b1}) begin
               next_state = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            // high keeps sampling, low finishes the cycle once rdy_ok is set
            if (rdy_ok && !ready_s) begin
               if (address_phase_wait_state && tristate_wait_state) begin
                  next_gap_cnt = `EBRA_MUX_TRI_GAP;
                  next_state = ST_GAP;
               end else if (address_phase_wait_state) begin
                  next_gap_cnt = `EBRA_MUX_GAP;
                  next_state = ST_GAP;
               end else if (tristate_wait_state) begin
                  next_gap_cnt = `EBRA_MUX_GAP;
                  next_state = ST_GAP;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_GAP: begin
            next_gap_cnt = gap_cnt - 3'h1;
            if (gap_cnt == 3'h1) begin
               next_state = ST_IDLE;
            end
         end
         ST_HELD: begin
            // only the hold pin going high restarts the regain sequence
            if (hold_edge && hold_s) begin
               next_state = ST_REGAIN;
            end
         end
         ST_REGAIN: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // state registers and bus clock
   // ****************************************************************
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         wait_cnt <= {WAIT_W{1'b0}};
         gap_cnt <= 3'h0;
         rdy_age <= 2'h0;
         clk_phase <= 1'b0;
         bus_clock_output <= 1'b0;
         cmd_write <= 1'b0;
         cmd_cs <= {CS_W{1'b1}};
      end else if (clk_en) begin
         state <= next_state;
         wait_cnt <= next_wait_cnt;
         gap_cnt <= next_gap_cnt;
         if (state == ST_IDLE) begin
            rdy_age <= 2'h0;
         end else if (rdy_age != 2'h3) begin
            rdy_age <= rdy_age + 2'h1;
         end
         clk_phase <= ~clk_phase;
         bus_clock_output <= ~clk_phase;
         if (state == ST_IDLE && next_state != ST_HELD && cyc_req) begin
            cmd_write <= cyc_write;
            cmd_cs <= cyc_cs;
         end
      end
   end

   // ****************************************************************
   // registered outputs
   // ****************************************************************
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cyc_ack <= 1'b0;
         cyc_done <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         cs_n_out <= {CS_W{1'b1}};
         cs_n_oe <= 1'b0;
         ctl_oe <= 1'b0;
         grant_acknowledge_out <= 1'b1;
         bus_regain_request <= 1'b1;
         bus_granted <= 1'b0;
      end else if (clk_en) begin
         cyc_ack <= (state == ST_IDLE) && (next_state != ST_IDLE)
            && (next_state != ST_HELD);
         cyc_done <= (state == ST_SAMPLE) && rdy_ok && !ready_s;
         if (next_state == ST_WAIT || next_state == ST_SAMPLE) begin
            rd_n <= cmd_write_n(state, cyc_write, cmd_write);
            wr_n <= ~rd_wr_sel(state, cyc_write, cmd_write);
            cs_n_out <= (state == ST_IDLE) ? cyc_cs : cmd_cs;
         end else if (next_state == ST_DELAY) begin
            cs_n_out <= cyc_cs;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
         end else begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            cs_n_out <= {CS_W{1'b1}};
         end
         if (next_state == ST_HELD) begin
            cs_n_oe <= 1'b1;
            ctl_oe <= 1'b1;
            grant_acknowledge_out <= 1'b0;
            bus_granted <= 1'b1;
         end else begin
            cs_n_oe <= 1'b0;
            ctl_oe <= 1'b0;
            grant_acknowledge_out <= 1'b1;
            bus_granted <= 1'b0;
         end
         // regain request only once the bus is released and acknowledged
         if (state == ST_HELD && !grant_acknowledge_out
               && next_state == ST_HELD) begin
            bus_regain_request <= ~own_need_bus;
         end else begin
            bus_regain_request <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // command select helpers
   // ****************************************************************
   function rd_wr_sel;
      input [2:0] st;
      input req_write;
      input held_write;
      begin
         rd_wr_sel = (st == ST_IDLE) ? req_write : held_write;
      end
   endfunction

   function cmd_write_n;
      input [2:0] st;
      input req_write;
      input held_write;
      begin
         cmd_write_n = (st == ST_IDLE) ? req_write : held_write;
      end
   endfunction
endmodule // ebra_ctrl

// *** sim/ebra_ctrl_chk.sv ***
module ebra_ctrl_chk (
   input wire ref_clk,
   input wire rstn,
   input wire rw_delay,
   input wire address_phase_wait_state,
   input wire tristate_wait_state,
   input wire ready_n,
   input wire hold_n,
   input wire cyc_ack,
   input wire cyc_done,
   input wire rd_n,
   input wire wr_n,
   input wire cs_n_oe,
   input wire ctl_oe,
   input wire grant_acknowledge_out,
   input wire bus_regain_request
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ******
   // cycle end and arbitration
   // ******
   sequence s_rdy_idle;
      ready_n [*4];
   endsequence
   sequence s_rdy_drop;
      $fell(ready_n) && !(rd_n && wr_n);
   endsequence
   AST_NO_EARLY_END: assert property (s_rdy_idle |=> !cyc_done)
      else $error("cycle ended without ready");
   AST_READY_ENDS: assert property (s_rdy_drop |-> ##[1:24] cyc_done)
      else $error("ready did not end cycle");
   AST_CMD_DELAY: assert property (cyc_ack |-> (rd_n && wr_n) == rw_delay)
      else $error("command edge misplaced");
   AST_GAP: assert property (cyc_done && address_phase_wait_state
      && tristate_wait_state |=> !cyc_ack [*4])
      else $error("gap too short");
   AST_GRANT_IDLE: assert property ($fell(grant_acknowledge_out)
      |-> rd_n && wr_n)
      else $error("granted inside a cycle");
   AST_FLOAT: assert property (!grant_acknowledge_out
      |-> cs_n_oe && ctl_oe)
      else $error("bus driven while granted");
   AST_REGAIN_HELD: assert property (!bus_regain_request
      |-> !grant_acknowledge_out)
      else $error("regain request while owning bus");
   AST_HOLD_HIGH: assert property ($fell(ctl_oe) |-> $past(hold_n, 2))
      else $error("regained while hold low");
   AST_REGAIN_DROP: assert property ($rose(bus_regain_request)
      |-> !ctl_oe && grant_acknowledge_out)
      else $error("regain request dropped early");
endmodule // ebra_ctrl_chk

bind ebra_ctrl ebra_ctrl_chk chk_u (.ref_clk, .rstn, .rw_delay,
   .address_phase_wait_state, .tristate_wait_state, .ready_n, .hold_n,
   .cyc_ack, .cyc_done, .rd_n, .wr_n, .cs_n_oe, .ctl_oe,
   .grant_acknowledge_out, .bus_regain_request);

// *** sim/ebra_slave_model.sv ***
module ebra_slave_model (
   input wire ref_clk,
   input wire rd_n,
   input wire wr_n,
   input wire [3:0] lat,
   output logic ready_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   initial ready_n = 1'b1;
   // answers lat+1 cycles after the command falls, held until it rises
   always @(posedge ref_clk) begin
      if (rd_n && wr_n) begin
         cnt <= 4'h0;
         ready_n <= 1'b1;
      end else begin
         if (cnt != 4'hf) cnt <= cnt + 4'h1;
         if (cnt >= lat) ready_n <= 1'b0;
      end
   end
endmodule // ebra_slave_model

// *** sim/tb_ebra_ctrl.sv ***
module tb_ebra_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rstn = 1'b0, cyc_req = 1'b0, cyc_write = 1'b0;
   logic rw_delay = 1'b0, address_phase_wait_state = 1'b0;
   logic tristate_wait_state = 1'b0, own_need_bus = 1'b0, hold_n = 1'b1;
   logic [4:0] cyc_cs = 5'h1f;
   logic [3:0] memory_cycle_wait_count = 4'h0, lat = 4'h0;
   wire ready_n, cyc_ack, cyc_done, bus_clock_output, rd_n, wr_n, cs_n_oe;
   wire ctl_oe, grant_acknowledge_out, bus_regain_request, bus_granted;
   wire [4:0] cs_n_out;
   int mismatches = 0, tests_run = 0, cycles = 0, n, g[4];
   always #2 ref_clk = ~ref_clk;
   ebra_ctrl dut_u (.ref_clk, .rstn, .clk_en(1'b1), .cyc_req, .cyc_write,
      .cyc_cs, .memory_cycle_wait_count, .rw_delay, .address_phase_wait_state,
      .tristate_wait_state, .own_need_bus, .ready_n, .hold_n, .cyc_ack,
      .cyc_done, .bus_clock_output, .rd_n, .wr_n, .cs_n_out, .cs_n_oe, .ctl_oe,
      .grant_acknowledge_out, .bus_regain_request, .bus_granted);
   ebra_slave_model slave_u (.ref_clk, .rd_n, .wr_n, .lat, .ready_n);
   task conclude;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         conclude();
      end
   end
   task chk(input string nm, input logic [7:0] e, input logic [7:0] v);
      tests_run++;
      if (v !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, v);
      end
   endtask
   function logic pick(input int s);
      case (s)
         0: pick = cyc_ack;
         1: pick = cyc_done;
         default: pick = grant_acknowledge_out;
      endcase
   endfunction
   // waits at falling edges, bounded, for a settled output value
   task automatic wt(input int s, input logic v);
      n = 0;
      @(negedge ref_clk);
      while (pick(s) !== v && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   task automatic run_cyc(input logic w, input logic [3:0] ws,
                          input logic dly, input logic keep);
      @(posedge ref_clk);
      cyc_write <= w;
      memory_cycle_wait_count <= ws;
      rw_delay <= dly;
      cyc_cs <= {w, 4'h6};
      cyc_req <= 1'b1;
      wt(0, 1'b1);
      chk("cmd_idle_at_ack", dly, rd_n & wr_n);
      @(posedge ref_clk);
      cyc_req <= keep;
      @(negedge ref_clk);
      chk("wr_n", !w, wr_n);
      chk("cs_n_out", {3'h0, w, 4'h6}, cs_n_out);
      chk("rd_n", w, rd_n);
      wt(1, 1'b1);
      chk("cyc_done", 1'b1, cyc_done);
   endtask
   task t_basic;
      for (int i = 0; i < 8; i++) begin
         lat = 4'(i * 2);
         run_cyc(i[0], 4'(i / 2), i[1], 1'b0);
      end
      @(negedge ref_clk);
      g[0] = bus_clock_output;
      @(negedge ref_clk);
      chk("bus_clock_output", 8'(!g[0]), bus_clock_output);
      $display("basic cycles done");
   endtask
   task t_gap;
      for (int i = 0; i < 4; i++) begin
         address_phase_wait_state <= i[0];
         tristate_wait_state <= i[1];
         run_cyc(1'b1, 4'h0, 1'b0, 1'b1);
         wt(0, 1'b1);
         g[i] = n;
         @(posedge ref_clk);
         cyc_req <= 1'b0;
         wt(1, 1'b1);
      end
      chk("gap_mux", 8'h02, 8'(g[1] - g[0]));
      chk("gap_tri", 8'h02, 8'(g[2] - g[0]));
      chk("gap_mux_tri", 8'h04, 8'(g[3] - g[0]));
      $display("gap test done");
   endtask
   task t_hold;
      lat = 4'h4;
      @(posedge ref_clk);
      cyc_req <= 1'b1;
      wt(0, 1'b1);
      @(posedge ref_clk);
      cyc_req <= 1'b0;
      hold_n <= 1'b0;
      while (cyc_done !== 1'b1) begin
         @(negedge ref_clk);
         if ((rd_n & wr_n) !== 1'b1) chk("ack_in_cycle", 1'b1, grant_acknowledge_out);
      end
      wt(2, 1'b0);
      chk("bus_granted", 1'b1, bus_granted);
      chk("cs_float", 1'b1, cs_n_oe);
      chk("ctl_float", 1'b1, ctl_oe);
      @(posedge ref_clk);
      cyc_req <= 1'b1;
      own_need_bus <= 1'b1;
      g[0] = 0;
      repeat (10) begin
         @(negedge ref_clk);
         if (cyc_ack === 1'b1) g[0]++;
      end
      chk("req_refused", 8'h00, 8'(g[0]));
      chk("regain_req", 1'b0, bus_regain_request);
      chk("still_held", 1'b0, grant_acknowledge_out);
      @(posedge ref_clk);
      hold_n <= 1'b1;
      wt(2, 1'b1);
      chk("regain_off", 1'b1, bus_regain_request);
      chk("cs_driven", 1'b0, cs_n_oe);
      wt(0, 1'b1);
      @(posedge ref_clk);
      cyc_req <= 1'b0;
      own_need_bus <= 1'b0;
      hold_n <= 1'b0;
      wt(1, 1'b1);
      chk("pending_done", 1'b1, cyc_done);
      wt(2, 1'b0);
      repeat (4) @(negedge ref_clk);
      chk("regain_unneeded", 1'b1, bus_regain_request);
      @(posedge ref_clk);
      hold_n <= 1'b1;
      wt(2, 1'b1);
      chk("regain_unasked", 1'b1, grant_acknowledge_out);
      $display("hold test done");
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      t_basic();
      t_gap();
      t_hold();
      conclude();
   end
endmodule // tb_ebra_ctrl
